// File: core/acl_match_entry.sv
// Contract
// (RL1) Source port criterion in don't-care ignores the source port.
// (RL2) Exact source mode matches only when source port equals the value.
// (RL3) Source range mode matches when source port lies within the bounds.
// (RL4) Destination port criterion in don't-care ignores the destination port.
// (RL5) Exact destination mode matches only on equal destination port.
// (RL6) Destination range mode matches when destination port lies within bounds.
// (RL7) FIN setting zero, one or don't-care.
// (RL8) SYN setting zero, one or don't-care.
// (RL9) RST setting zero, one or don't-care.
// (RL10) PSH setting zero, one or don't-care.
// (RL11) ACK setting zero, one or don't-care.
// (RL12) URG setting zero, one or don't-care.
// (RL13) EtherType criteria apply only when frame type selects EtherType.
// (RL14) EtherType don't-care skips the EtherType comparison.
// (RL15) Exact EtherType matches only on equal 16-bit type value.
// (RL16) Software never programs the IPv4, ARP or IPv6 type codes.
// (RL17) The entry hits only when all criteria hold together.
// (RL18) Port criteria need TCP/UDP; flag criteria need TCP.
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module acl_match_entry #(
    parameter int PORT_W = 16
) (
    input  wire logic                 pclk,         // Clock, 100 MHz.
    input  wire logic                 presetn,      // Async reset, active low.
    input  wire logic                 psel,         // APB select.
    input  wire logic                 penable,      // APB enable.
    input  wire logic                 pwrite,       // APB direction.
    input  wire logic [11:0]          paddr,        // APB byte address.
    input  wire logic [31:0]          pwdata,       // APB write data.
    output logic      [31:0]          prdata,       // APB read data.
    output logic                      pready,       // APB ready.
    output logic                      pslverr,      // APB error.
    input  wire logic                 frame_valid,  // Parsed header valid.
    input  wire acl_match_pkg::frame_s frame,       // Parsed header fields.
    output logic                      match_valid,  // Decision valid.
    output logic                      match_hit     // Entry matched.
);

    // ======================================================================
    // Configuration and status state.
    logic [7:0]        ctrl_q;
    logic [31:0]       src_q;
    logic [31:0]       dst_q;
    logic [11:0]       flags_q;
    logic [15:0]       etype_q;
    logic [15:0]       hit_cnt_q;
    logic              last_hit_q;

    logic              setup;
    logic              access;
    logic              addr_ok;
    logic [31:0]       rd_mux;
    logic              src_ok;
    logic              dst_ok;
    logic              l4_present;
    logic [5:0]        flag_ok;
    logic              etype_ok;
    logic              entry_en;
    logic              all_ok;
    acl_match_pkg::frame_type_e ftype;
    acl_match_pkg::port_mode_e  src_mode;
    acl_match_pkg::port_mode_e  dst_mode;

    // ======================================================================
    // APB slave.

    // Phase decode of the bus.
    assign setup  = psel & ~penable;
    assign access = psel & penable & pready;

    // Address decode and read data selection.
    always_comb begin
        addr_ok = 1'b1;
        rd_mux  = 32'h0000_0000;
        unique case (paddr)
            acl_match_pkg::ADDR_CTRL: begin
                rd_mux[acl_match_pkg::CTRL_W-1:0] = ctrl_q;
            end
            acl_match_pkg::ADDR_SRC: begin
                rd_mux = src_q;
            end
            acl_match_pkg::ADDR_DST: begin
                rd_mux = dst_q;
            end
            acl_match_pkg::ADDR_FLAGS: begin
                rd_mux[11:0] = flags_q;
            end
            acl_match_pkg::ADDR_ETYPE: begin
                rd_mux[15:0] = etype_q;
            end
            acl_match_pkg::ADDR_STATUS: begin
                rd_mux[acl_match_pkg::STAT_HIT_BIT] = last_hit_q;
                rd_mux[acl_match_pkg::STAT_CNT_LSB +: 16] = hit_cnt_q;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    // Ready comes one cycle after setup, so every access has no wait state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    // Error and read data are captured in the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (setup) begin
            pslverr <= ~addr_ok;
            prdata  <= (pwrite || !addr_ok) ? 32'h0000_0000 : rd_mux;
        end else begin
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
    end

    // Writes land at the access edge; status is read-only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= acl_match_pkg::CTRL_RST;
            src_q   <= {acl_match_pkg::PORT_RST, acl_match_pkg::PORT_RST};
            dst_q   <= {acl_match_pkg::PORT_RST, acl_match_pkg::PORT_RST};
            flags_q <= acl_match_pkg::FLAGS_RST;
            etype_q <= acl_match_pkg::ETYPE_RST;
        end else if (access && pwrite && !pslverr) begin
            unique case (paddr)
                acl_match_pkg::ADDR_CTRL: begin
                    ctrl_q <= pwdata[acl_match_pkg::CTRL_W-1:0];
                end
                acl_match_pkg::ADDR_SRC: begin
                    src_q <= pwdata;  // RL2 RL3
                end
                acl_match_pkg::ADDR_DST: begin
                    dst_q <= pwdata;  // RL5 RL6
                end
                acl_match_pkg::ADDR_FLAGS: begin
                    flags_q <= pwdata[11:0];
                end
                acl_match_pkg::ADDR_ETYPE: begin
                    etype_q <= pwdata[15:0];  // RL15
                end
                default: begin
                    ctrl_q <= ctrl_q;
                end
            endcase
        end
    end

    // ======================================================================
    // Match evaluation.

    // Mode fields taken from the control register.
    assign src_mode = acl_match_pkg::port_mode_e'(ctrl_q[acl_match_pkg::CTRL_SRC_LSB +: 2]);
    assign dst_mode = acl_match_pkg::port_mode_e'(ctrl_q[acl_match_pkg::CTRL_DST_LSB +: 2]);
    assign ftype    = acl_match_pkg::frame_type_e'(ctrl_q[acl_match_pkg::CTRL_FT_LSB +: 2]);
    assign entry_en = ctrl_q[acl_match_pkg::CTRL_EN_BIT];

    // Port criteria only see frames that carry a TCP or UDP header.
    assign l4_present = frame.is_tcp | frame.is_udp;  // RL18

    // Source port criterion.
    port_criterion #(
        .PORT_W (PORT_W)
    ) u_src (
        .mode    (ctrl_q[acl_match_pkg::CTRL_SRC_LSB +: 2]),  // RL1 RL2 RL3
        .lo      (src_q[PORT_W-1:0]),
        .hi      (src_q[acl_match_pkg::HI_LSB +: PORT_W]),
        .port    (frame.sport),
        .present (l4_present),
        .ok      (src_ok)
    );

    // Destination port criterion.
    port_criterion #(
        .PORT_W (PORT_W)
    ) u_dst (
        .mode    (ctrl_q[acl_match_pkg::CTRL_DST_LSB +: 2]),  // RL4 RL5 RL6
        .lo      (dst_q[PORT_W-1:0]),
        .hi      (dst_q[acl_match_pkg::HI_LSB +: PORT_W]),
        .port    (frame.dport),
        .present (l4_present),
        .ok      (dst_ok)
    );

    // Three-way TCP flag criteria; codes other than zero and one are don't-care.
    for (genvar i = 0; i < acl_match_pkg::NUM_FLAGS; i++) begin : g_flag
        logic [1:0] fm;
        assign fm = flags_q[i*acl_match_pkg::FLAG_FLD_W +: acl_match_pkg::FLAG_FLD_W];
        always_comb begin
            flag_ok[i] = 1'b1;  // RL7 RL8 RL9 RL10 RL11 RL12
            if (fm == acl_match_pkg::FLAG_ZERO) begin
                flag_ok[i] = frame.is_tcp & ~frame.tcp_flags[i];  // RL18
            end else if (fm == acl_match_pkg::FLAG_ONE) begin
                flag_ok[i] = frame.is_tcp & frame.tcp_flags[i];
            end
        end
    end

    // EtherType criterion, used only when the frame type selects it.
    always_comb begin
        etype_ok = 1'b1;
        if (ftype == acl_match_pkg::FT_ETHTYPE) begin  // RL13
            if (ctrl_q[acl_match_pkg::CTRL_ETM_BIT]) begin  // RL14
                etype_ok = (frame.ethertype == etype_q);  // RL15
            end
        end
    end

    // All criteria are combined by AND.
    assign all_ok = entry_en & src_ok & dst_ok & (&flag_ok) & etype_ok;  // RL17

    // Registered decision towards the forwarding logic.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_valid <= 1'b0;
            match_hit   <= 1'b0;
        end else begin
            match_valid <= frame_valid;
            match_hit   <= frame_valid & all_ok;  // RL17
        end
    end

    // Status: last decision and a wrapping hit counter.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_hit_q <= 1'b0;
            hit_cnt_q  <= 16'h0000;
        end else if (frame_valid) begin
            last_hit_q <= all_ok;
            if (all_ok) begin
                hit_cnt_q <= hit_cnt_q + 16'h0001;
            end
        end
    end

    // ======================================================================
    // Assertions.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // A frame arrives and its decision is a miss one cycle later.
    sequence s_frame;
        frame_valid;
    endsequence
    sequence s_miss;
        match_valid && !match_hit;
    endsequence

    a_src_any_pass: assert property (src_mode == acl_match_pkg::PORT_ANY |-> src_ok) // RL1
        else $error("source don't-care rejected a frame");
    a_src_exact_miss: assert property (s_frame and (src_mode == acl_match_pkg::PORT_EXACT // RL2
        && frame.sport != src_q[15:0]) |=> s_miss)
        else $error("source exact mismatch still hit");
    a_src_range_miss: assert property (s_frame and (src_mode == acl_match_pkg::PORT_RANGE // RL3
        && (frame.sport < src_q[15:0] || frame.sport > src_q[31:16])) |=> s_miss)
        else $error("source out of range still hit");
    a_dst_any_pass: assert property (dst_mode == acl_match_pkg::PORT_ANY |-> dst_ok) // RL4
        else $error("destination don't-care rejected a frame");
    a_dst_exact_miss: assert property (s_frame and (dst_mode == acl_match_pkg::PORT_EXACT // RL5
        && frame.dport != dst_q[15:0]) |=> s_miss)
        else $error("destination exact mismatch still hit");
    a_dst_range_miss: assert property (s_frame and (dst_mode == acl_match_pkg::PORT_RANGE // RL6
        && (frame.dport < dst_q[15:0] || frame.dport > dst_q[31:16])) |=> s_miss)
        else $error("destination out of range still hit");

    for (genvar j = 0; j < acl_match_pkg::NUM_FLAGS; j++) begin : g_flag_chk
        a_flag_value_miss: assert property (s_frame and (frame.is_tcp // RL7 RL8 RL9 RL10 RL11 RL12
            && ((g_flag[j].fm == acl_match_pkg::FLAG_ZERO && frame.tcp_flags[j])
            || (g_flag[j].fm == acl_match_pkg::FLAG_ONE && !frame.tcp_flags[j]))) |=> s_miss)
            else $error("tcp flag criterion violated but hit");
        a_flag_tcp_only: assert property (s_frame and (!frame.is_tcp // RL18
            && (g_flag[j].fm == acl_match_pkg::FLAG_ZERO || g_flag[j].fm == acl_match_pkg::FLAG_ONE)) |=> s_miss)
            else $error("flag criterion hit a non tcp frame");
    end

    a_etype_class_only: assert property (ftype != acl_match_pkg::FT_ETHTYPE |-> etype_ok) // RL13
        else $error("ethertype used outside its frame type");
    a_etype_any_pass: assert property (!ctrl_q[acl_match_pkg::CTRL_ETM_BIT] |-> etype_ok) // RL14
        else $error("ethertype don't-care compared the field");
    a_etype_exact_miss: assert property (s_frame and (ftype == acl_match_pkg::FT_ETHTYPE // RL15
        && ctrl_q[acl_match_pkg::CTRL_ETM_BIT] && frame.ethertype != etype_q) |=> s_miss)
        else $error("ethertype mismatch still hit");
    a_all_and_hit: assert property (s_frame and all_ok |=> match_valid && match_hit // RL17
        && last_hit_q)
        else $error("all criteria held but no hit");
    a_no_l4_miss: assert property (s_frame and (!frame.is_tcp && !frame.is_udp // RL18
        && src_mode == acl_match_pkg::PORT_EXACT) |=> s_miss)
        else $error("port criterion hit a frame without l4 header");
    a_no_l4_dst_miss: assert property (s_frame and (!frame.is_tcp && !frame.is_udp // RL18
        && dst_mode == acl_match_pkg::PORT_EXACT) |=> s_miss)
        else $error("destination criterion hit a frame without l4 header");

    // A decision that reports a hit.
    sequence s_hit;
        match_valid && match_hit;
    endsequence

    // No decision comes without a frame, and a disabled entry never hits.
    a_idle_no_decision: assert property (!frame_valid |=> !match_valid && !match_hit) // RL17
        else $error("decision without a frame");
    a_disabled_miss: assert property (s_frame and !entry_en |=> s_miss) // RL17
        else $error("disabled entry still hit");

    // The hit counter steps once for every hit and wraps.
    a_hit_count_step: assert property (s_frame and all_ok // RL17
        |=> hit_cnt_q == $past(hit_cnt_q) + 16'h0001)
        else $error("hit counter did not step");

    // With all other criteria met, the criterion under watch alone must give the hit.
    a_src_exact_hit: assert property (s_frame and (entry_en && dst_ok && (&flag_ok) && etype_ok // RL2
        && src_mode == acl_match_pkg::PORT_EXACT && l4_present
        && frame.sport == src_q[15:0]) |=> s_hit)
        else $error("source exact match missed");
    a_src_range_hit: assert property (s_frame and (entry_en && dst_ok && (&flag_ok) && etype_ok // RL3
        && src_mode == acl_match_pkg::PORT_RANGE && l4_present
        && frame.sport >= src_q[15:0] && frame.sport <= src_q[31:16]) |=> s_hit)
        else $error("source in range missed");
    a_dst_exact_hit: assert property (s_frame and (entry_en && src_ok && (&flag_ok) && etype_ok // RL5
        && dst_mode == acl_match_pkg::PORT_EXACT && l4_present
        && frame.dport == dst_q[15:0]) |=> s_hit)
        else $error("destination exact match missed");
    a_dst_range_hit: assert property (s_frame and (entry_en && src_ok && (&flag_ok) && etype_ok // RL6
        && dst_mode == acl_match_pkg::PORT_RANGE && l4_present
        && frame.dport >= dst_q[15:0] && frame.dport <= dst_q[31:16]) |=> s_hit)
        else $error("destination in range missed");
    a_etype_exact_hit: assert property (s_frame and (entry_en && src_ok && dst_ok && (&flag_ok) // RL15
        && ftype == acl_match_pkg::FT_ETHTYPE && ctrl_q[acl_match_pkg::CTRL_ETM_BIT]
        && frame.ethertype == etype_q) |=> s_hit)
        else $error("ethertype match missed");

endmodule
`default_nettype wire

// File: core/acl_match_pkg.sv
// ==========================================================================
// Shared constants and types for the match entry.
package acl_match_pkg;

    // ======================================================================
    // Register map, byte addresses on APB.
    localparam int          ADDR_W      = 12;
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_SRC    = 12'h004;
    localparam logic [11:0] ADDR_DST    = 12'h008;
    localparam logic [11:0] ADDR_FLAGS  = 12'h00C;
    localparam logic [11:0] ADDR_ETYPE  = 12'h010;
    localparam logic [11:0] ADDR_STATUS = 12'h014;

    // ======================================================================
    // Field positions.
    localparam int CTRL_SRC_LSB  = 0;
    localparam int CTRL_DST_LSB  = 2;
    localparam int CTRL_ETM_BIT  = 4;
    localparam int CTRL_FT_LSB   = 5;
    localparam int CTRL_EN_BIT   = 7;
    localparam int CTRL_W        = 8;
    localparam int HI_LSB        = 16;
    localparam int FLAG_FLD_W    = 2;
    localparam int NUM_FLAGS     = 6;
    localparam int STAT_HIT_BIT  = 0;
    localparam int STAT_CNT_LSB  = 16;

    // ======================================================================
    // Reset values.
    localparam logic [7:0]  CTRL_RST  = 8'h00;
    localparam logic [11:0] FLAGS_RST = 12'hFFF;
    localparam logic [15:0] PORT_RST  = 16'h0000;
    localparam logic [15:0] ETYPE_RST = 16'h0600;

    // ======================================================================
    // Criterion modes.
    typedef enum logic [1:0] {PORT_ANY, PORT_EXACT, PORT_RANGE} port_mode_e;
    typedef enum logic [1:0] {FLAG_ZERO, FLAG_ONE, FLAG_ANY} flag_mode_e;
    typedef enum logic [1:0] {FT_ANY, FT_ETHTYPE, FT_OTHER} frame_type_e;

    // Header fields handed over by the ingress parser.
    typedef struct packed {
        logic        is_tcp;
        logic        is_udp;
        logic [15:0] sport;
        logic [15:0] dport;
        logic [15:0] ethertype;
        logic [5:0]  tcp_flags;  // Bit 0 FIN, 1 SYN, 2 RST, 3 PSH, 4 ACK, 5 URG.
    } frame_s;

endpackage

// File: core/port_criterion.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// One layer-4 port criterion: don't-care, exact value or inclusive range.
module port_criterion #(
    parameter int PORT_W = 16
) (
    input  wire logic [1:0]        mode,     // Criterion mode code.
    input  wire logic [PORT_W-1:0] lo,       // Exact value or lower bound.
    input  wire logic [PORT_W-1:0] hi,       // Upper bound of the range.
    input  wire logic [PORT_W-1:0] port,     // Port number of the frame.
    input  wire logic              present,  // Frame carries a TCP/UDP header.
    output logic                   ok        // Criterion satisfied.
);

    acl_match_pkg::port_mode_e m;

    // Decode the mode; the unused code behaves as don't-care.
    always_comb begin
        m  = acl_match_pkg::port_mode_e'(mode);
        ok = 1'b1;
        unique case (m)
            acl_match_pkg::PORT_ANY: begin
                ok = 1'b1;
            end
            acl_match_pkg::PORT_EXACT: begin
                ok = present & (port == lo);
            end
            acl_match_pkg::PORT_RANGE: begin
                ok = present & (port >= lo) & (port <= hi);
            end
            default: begin
                ok = 1'b1;
            end
        endcase
    end

endmodule
`default_nettype wire

// File: tb/frame_src.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Ingress parser model: hands one parsed header at a time to the entry.
module frame_src (
    input  wire logic             pclk,         // Clock shared with the entry.
    output logic                  frame_valid,  // One-cycle header strobe.
    output acl_match_pkg::frame_s frame         // Parsed header fields.
);
    // Idle at time zero with nothing offered.
    initial begin
        frame_valid = 1'b0;
        frame       = '0;
    end

    // Offers one header for one cycle, then scrambles the fields so stale data never looks valid.
    task automatic send(input acl_match_pkg::frame_s f);
        @(posedge pclk);
        frame_valid <= 1'b1;
        frame       <= f;
        @(posedge pclk);
        frame_valid <= 1'b0;
        frame       <= ~f;
    endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Self-checking bench for one match entry.
module tb_top;
    logic                  pclk;
    logic                  presetn;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [11:0]           paddr;
    logic [31:0]           pwdata;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  frame_valid;
    acl_match_pkg::frame_s frame;
    logic                  match_valid;
    logic                  match_hit;
    int                    n_fail;
    int                    n_tests;
    int                    n_hits;
    logic                  last_hit;
    logic [31:0]           rd;
    logic                  err;

    acl_match_entry i_acl_match_entry (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .frame_valid(frame_valid), .frame(frame), .match_valid(match_valid),
        .match_hit(match_hit));
    frame_src i_frame_src (.pclk(pclk), .frame_valid(frame_valid), .frame(frame));

    // ======================================================================
    // Helpers.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // One APB transfer; read data and error are taken at the edge where pready is sampled high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic acl_match_pkg::frame_s mk(input logic tcp, input logic udp, input logic [15:0] sp,
                                                 input logic [15:0] dp, input logic [15:0] et,
                                                 input logic [5:0] fl);
        return '{is_tcp: tcp, is_udp: udp, sport: sp, dport: dp, ethertype: et, tcp_flags: fl};
    endfunction

    // Sends a header and judges the decision one cycle later.
    task automatic fchk(input acl_match_pkg::frame_s f, input logic exp);
        i_frame_src.send(f);
        #1;
        chk({31'h0, match_valid}, 32'h1);
        chk({31'h0, match_hit}, {31'h0, exp});
        if (exp) n_hits++;
        last_hit = exp;
    endtask

    // ======================================================================
    // Scenarios.
    task automatic t_reset();
        logic [11:0] a [6];
        logic [31:0] e [6];
        a = '{acl_match_pkg::ADDR_CTRL, acl_match_pkg::ADDR_SRC, acl_match_pkg::ADDR_DST,
              acl_match_pkg::ADDR_FLAGS, acl_match_pkg::ADDR_ETYPE, acl_match_pkg::ADDR_STATUS};
        e = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0FFF, 32'h0000_0600, 32'h0000_0000};
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, a[i], 32'h0);
            chk(rd, e[i]);
            chk({31'h0, err}, 32'h0);
        end
        apb(1'b1, 12'h018, 32'hFFFF_FFFF);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 12'h018, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h1);
        fchk(mk(1'b1, 1'b0, 16'h0, 16'h0, 16'h0600, 6'h0), 1'b0);
    endtask

    // Exact, range and don't-care on either port field.
    task automatic t_ports(input logic dst);
        logic [11:0] a;
        int          sh;
        logic [15:0] p [8];
        logic        e [8];
        a  = dst ? acl_match_pkg::ADDR_DST : acl_match_pkg::ADDR_SRC;
        sh = dst ? 2 : 0;
        apb(1'b1, acl_match_pkg::ADDR_CTRL, 32'h80 | (32'h1 << sh));
        apb(1'b1, a, 32'h0000_1234);
        p = '{16'h1234, 16'h1235, 16'h00FF, 16'h0100, 16'h0200, 16'h0201, 16'h1234, 16'h0000};
        e = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
        for (int i = 0; i < 2; i++) begin
            fchk(mk(1'b1, 1'b0, dst ? 16'h0 : p[i], dst ? p[i] : 16'h0, 16'h0600, 6'h0), e[i]);
        end
        fchk(mk(1'b0, 1'b1, dst ? 16'h0 : p[0], dst ? p[0] : 16'h0, 16'h0600, 6'h0), 1'b1);
        fchk(mk(1'b0, 1'b0, dst ? 16'h0 : p[0], dst ? p[0] : 16'h0, 16'h0600, 6'h0), 1'b0);
        apb(1'b1, acl_match_pkg::ADDR_CTRL, 32'h80 | (32'h2 << sh));
        apb(1'b1, a, 32'h0200_0100);
        for (int i = 2; i < 6; i++) begin
            fchk(mk(1'b0, 1'b1, dst ? 16'h0 : p[i], dst ? p[i] : 16'h0, 16'h0600, 6'h0), e[i]);
        end
        apb(1'b1, acl_match_pkg::ADDR_CTRL, 32'h80);
        fchk(mk(1'b1, 1'b0, dst ? 16'h0 : p[5], dst ? p[5] : 16'h0, 16'h0600, 6'h0), 1'b1);
    endtask

    // Every flag under each of its three settings.
    task automatic t_flags();
        logic [11:0] f;
        for (int i = 0; i < 6; i++) begin
            for (int m = 0; m < 3; m++) begin
                f = (12'hFFF & ~(12'h3 << (2 * i))) | (12'(m) << (2 * i));
                apb(1'b1, acl_match_pkg::ADDR_FLAGS, {20'h0, f});
                fchk(mk(1'b1, 1'b0, 16'h0, 16'h0, 16'h0600, 6'h3F), m != 0);
                fchk(mk(1'b1, 1'b0, 16'h0, 16'h0, 16'h0600, ~(6'h1 << i)), m != 1);
                fchk(mk(1'b0, 1'b1, 16'h0, 16'h0, 16'h0600, 6'h3F), m == 2);
            end
        end
        apb(1'b1, acl_match_pkg::ADDR_FLAGS, 32'h0000_0FFF);
    endtask

    // EtherType value is arbitrary and kept off the reserved type codes.
    task automatic t_etype();
        apb(1'b1, acl_match_pkg::ADDR_ETYPE, 32'h0000_88B5);
        apb(1'b0, acl_match_pkg::ADDR_ETYPE, 32'h0);
        chk(rd, 32'h0000_88B5);
        apb(1'b1, acl_match_pkg::ADDR_CTRL, 32'hB0);
        fchk(mk(1'b0, 1'b0, 16'h0, 16'h0, 16'h88B5, 6'h0), 1'b1);
        fchk(mk(1'b0, 1'b0, 16'h0, 16'h0, 16'h88B6, 6'h0), 1'b0);
        apb(1'b1, acl_match_pkg::ADDR_CTRL, 32'h90);
        fchk(mk(1'b0, 1'b0, 16'h0, 16'h0, 16'h88B6, 6'h0), 1'b1);
        apb(1'b1, acl_match_pkg::ADDR_CTRL, 32'hA0);
        fchk(mk(1'b0, 1'b0, 16'h0, 16'h0, 16'h88B6, 6'h0), 1'b1);
        apb(1'b1, acl_match_pkg::ADDR_CTRL, 32'hD0);
        fchk(mk(1'b0, 1'b0, 16'h0, 16'h0, 16'h88B6, 6'h0), 1'b1);
        apb(1'b1, acl_match_pkg::ADDR_CTRL, 32'hF0);
        fchk(mk(1'b0, 1'b0, 16'h0, 16'h0, 16'h88B6, 6'h0), 1'b1);
        apb(1'b1, acl_match_pkg::ADDR_CTRL, 32'h8F);
        fchk(mk(1'b1, 1'b0, 16'h1235, 16'h0, 16'h0600, 6'h0), 1'b1);
        apb(1'b1, acl_match_pkg::ADDR_SRC, 32'h0000_1234);
        apb(1'b1, acl_match_pkg::ADDR_CTRL, 32'hB1);
        fchk(mk(1'b1, 1'b0, 16'h1235, 16'h0, 16'h88B5, 6'h0), 1'b0);
        fchk(mk(1'b1, 1'b0, 16'h1234, 16'h0, 16'h88B6, 6'h0), 1'b0);
        fchk(mk(1'b1, 1'b0, 16'h1234, 16'h0, 16'h88B5, 6'h0), 1'b1);
        apb(1'b1, acl_match_pkg::ADDR_STATUS, 32'h0);
        apb(1'b0, acl_match_pkg::ADDR_STATUS, 32'h0);
        chk(rd, {n_hits[15:0], 15'h0, last_hit});
    endtask

    // ======================================================================
    // Verdict, clock, watchdog and main sequence.
    task automatic test_done();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Free-running 100 MHz clock.
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Cuts a hang short well past the expected run length.
    initial begin
        #200000;
        n_fail++;
        test_done();
    end

    // Reset for ten cycles, then every scenario in turn.
    initial begin
        n_fail   = 0;
        n_tests  = 0;
        n_hits   = 0;
        last_hit = 1'b0;
        presetn  = 1'b0;
        psel     = 1'b0;
        penable  = 1'b0;
        pwrite   = 1'b0;
        paddr    = 12'h000;
        pwdata   = 32'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_ports(1'b0);
        t_ports(1'b1);
        t_flags();
        t_etype();
        test_done();
    end
endmodule
`default_nettype wire
